/* ebmp_port.sv */
// Bus mastership arbitration and master-only strobes
`timescale 1ns/1ps
`include "ebmp_map.svh"
module ebmp_port (
	input  wire logic clk,
	input  wire logic rstn,
	input  wire logic grant_in_n,
	input  wire logic shared_busy_n_i,
	output logic      shared_busy_n_o,
	output logic      shared_busy_n_oe,
	output logic      request_out_n,
	input  wire logic bus_need,
	input  wire logic cycle_active,
	input  wire logic cycle_end,
	input  wire logic request_hold_bit,
	input  wire logic mastership_strobe_enable,
	input  wire logic bus_clock_enable,
	input  wire logic cas_req,
	output logic      owner,
	output logic      col_strobe_n_o,
	output logic      col_strobe_n_oe,
	output logic      bus_clock_o,
	output logic      bus_clock_oe,
	output logic      bus_clock_n_o,
	output logic      bus_clock_n_oe
);
	import ebmp_pkg::*;

	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic grant_s_n;
	logic busy_s_n;

	ebmp_sync u_sync_grant (
		.clk  (clk),
		.rstn (rstn),
		.din  (grant_in_n),
		.dout (grant_s_n)
	);

	ebmp_sync u_sync_busy (
		.clk  (clk),
		.rstn (rstn),
		.din  (shared_busy_n_i),
		.dout (busy_s_n)
	);

	// ****************************************
	// Arbitration state machine
	// ****************************************
	ebmp_state_t state_q;
	ebmp_state_t state_d;
	logic        req_n_q;
	logic        req_n_d;
	logic        busy_o_q;
	logic        busy_o_d;
	logic        busy_oe_q;
	logic        busy_oe_d;
	logic        bclk_q;
	logic        bclk_d;
	logic        cas_q;
	logic        cas_d;
	logic        own;

	assign own = (state_q == EBMP_OWNER) || (state_q == EBMP_PARKED);

	// Next state, busy drive and request in one place
	always_comb
	begin
		state_d   = state_q;
		busy_o_d  = busy_o_q;
		busy_oe_d = busy_oe_q;
		req_n_d   = !(bus_need || request_hold_bit);
		unique case (state_q)
			EBMP_SLAVE:
			begin
				busy_oe_d = 1'b0;
				if (!req_n_q)
					state_d = EBMP_WAIT;
			end
			EBMP_WAIT:
			begin
				// Both pins arrive two flops late
				busy_oe_d = 1'b0;
				if (req_n_q)
					state_d = EBMP_SLAVE;
				else if (!grant_s_n && busy_s_n)
				begin
					state_d   = EBMP_OWNER;
					busy_o_d  = 1'b0;
					busy_oe_d = 1'b1;
				end
			end
			EBMP_OWNER:
			begin
				if (grant_s_n && (!cycle_active || cycle_end))
				begin
					state_d  = EBMP_RELEASE;
					busy_o_d = 1'b1;
				end
				else if (!cycle_active && !bus_need)
					state_d = EBMP_PARKED;
			end
			EBMP_PARKED:
			begin
				if (grant_s_n)
				begin
					state_d  = EBMP_RELEASE;
					busy_o_d = 1'b1;
				end
				else if (bus_need)
					state_d = EBMP_OWNER;
			end
			// Busy is driven high during this state; float it from the next cycle
			EBMP_RELEASE:
			begin
				state_d   = EBMP_SLAVE;
				busy_oe_d = 1'b0;
			end
			default:
				state_d = EBMP_SLAVE;
		endcase
	end

	// ****************************************
	// Strobes while owner
	// ****************************************
	always_comb
	begin
		// Bus clock toggles at half the core rate
		bclk_d = (state_d == EBMP_OWNER || state_d == EBMP_PARKED) && bus_clock_enable
			&& !bclk_q;
		cas_d  = !(cas_req && (state_d == EBMP_OWNER));
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state_q   <= EBMP_SLAVE;
			req_n_q   <= `EBMP_RST_REQ_N;
			busy_o_q  <= 1'b1;
			busy_oe_q <= 1'b0;
			bclk_q    <= 1'b0;
			cas_q     <= 1'b1;
		end
		else
		begin
			state_q   <= state_d;
			req_n_q   <= req_n_d;
			busy_o_q  <= busy_o_d;
			busy_oe_q <= busy_oe_d;
			bclk_q    <= bclk_d;
			cas_q     <= cas_d;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	// Quarter-period lead needs the PLL; here the edge aligns to clk
	assign request_out_n    = req_n_q;
	assign shared_busy_n_o  = busy_o_q;
	assign shared_busy_n_oe = busy_oe_q;
	assign owner            = own;
	assign col_strobe_n_o   = cas_q;
	assign col_strobe_n_oe  = own || mastership_strobe_enable;
	assign bus_clock_o      = bclk_q;
	assign bus_clock_oe     = own;
	assign bus_clock_n_o    = !bclk_q;
	assign bus_clock_n_oe   = own;

	// ****************************************
	// Checks
	// ****************************************
	a_slave_no_drive: assert property (@(posedge clk) disable iff (!rstn)
		(state_q == EBMP_SLAVE) |-> !shared_busy_n_oe)
		else $error("busy driven in slave state");
	a_take_after_release: assert property (@(posedge clk) disable iff (!rstn)
		$rose(owner) && $past(state_q) == EBMP_WAIT |-> $past(busy_s_n) && $past(!grant_s_n))
		else $error("ownership taken while busy or ungranted");
	a_owner_busy_low: assert property (@(posedge clk) disable iff (!rstn)
		owner |-> shared_busy_n_oe && !shared_busy_n_o)
		else $error("owner not driving busy low");
	a_release_high: assert property (@(posedge clk) disable iff (!rstn)
		$fell(owner) |-> shared_busy_n_oe && shared_busy_n_o ##1 !shared_busy_n_oe)
		else $error("busy release not active pull-up");
	a_grant_loss: assert property (@(posedge clk) disable iff (!rstn)
		(state_q == EBMP_PARKED) && grant_s_n |=> !owner)
		else $error("parked bus kept after grant loss");
	a_wait_hold_off: assert property (@(posedge clk) disable iff (!rstn)
		(state_q == EBMP_WAIT) && !busy_s_n |=> !owner)
		else $error("ownership taken while busy seen low");
	a_slave_ignore: assert property (@(posedge clk) disable iff (!rstn)
		(state_q == EBMP_SLAVE) |=> !owner)
		else $error("ownership taken straight from slave");
	a_release_float: assert property (@(posedge clk) disable iff (!rstn)
		(state_q == EBMP_RELEASE) |=> (state_q == EBMP_SLAVE) && !shared_busy_n_oe)
		else $error("busy not floated after release");
	a_request_need: assert property (@(posedge clk) disable iff (!rstn)
		bus_need |=> !request_out_n)
		else $error("request not raised for bus need");
	a_request_drop: assert property (@(posedge clk) disable iff (!rstn)
		!bus_need && !request_hold_bit |=> request_out_n)
		else $error("request kept without need");

	// ****************************************
	// Checks on the bus clock, strobes and request hold
	// ****************************************
	a_bclk_gate: assert property (@(posedge clk) disable iff (!rstn)
		!owner |-> !bus_clock_o)
		else $error("bus clock toggles while not owner");
	a_bclk_inverse: assert property (@(posedge clk) disable iff (!rstn)
		bus_clock_n_o == !bus_clock_o && bus_clock_n_oe == owner)
		else $error("inverted bus clock wrong");
	a_request_hold: assert property (@(posedge clk) disable iff (!rstn)
		request_hold_bit |=> !request_out_n)
		else $error("request hold not honoured");
	a_cas_tristate: assert property (@(posedge clk) disable iff (!rstn)
		!owner && !mastership_strobe_enable |-> !col_strobe_n_oe)
		else $error("column strobe driven when not allowed");
	a_bclk_toggle: assert property (@(posedge clk) disable iff (!rstn)
		owner && $past(bus_clock_enable) |-> bus_clock_o != $past(bus_clock_o))
		else $error("bus clock stalled while owner and enabled");
	a_cas_owner: assert property (@(posedge clk) disable iff (!rstn)
		!col_strobe_n_o |-> owner)
		else $error("column strobe low while not owner");
endmodule : ebmp_port

/* ebmp_map.svh */
// Constants and operation summary of the external bus mastership port
// Operation
// - Granted device waits for busy release
// - Grant removal ends ownership after cycle
// - Busy line moves only on core clock
// - Take ownership after release, reassert busy
// - Owner may park, keeping busy asserted
// - Release busy: drive high, then float
// - Column strobe driven as owner or with strobe enable set, else tristate
// - Bus clock toggles when owner and enabled
// - Bus clock edge aligns to core clock; quarter-period lead needs the PLL
// - Inverted bus clock driven only as owner
// - Request asserted while bus is needed
// - Request-hold bit forces request asserted
// - Reset deasserts request, returns to slave
`ifndef EBMP_MAP_SVH
`define EBMP_MAP_SVH
`define EBMP_RELEASE_DRIVE_CYC 1
`define EBMP_RST_REQ_N 1'b1
`endif

/* ebmp_pkg.sv */
// Types of the external bus mastership port
package ebmp_pkg;
	typedef enum logic [2:0] {
		EBMP_SLAVE,
		EBMP_WAIT,
		EBMP_OWNER,
		EBMP_PARKED,
		EBMP_RELEASE
	} ebmp_state_t;
endpackage : ebmp_pkg

/* ebmp_sync.sv */
// Two flip-flop synchroniser for one pin
`timescale 1ns/1ps
module ebmp_sync (
	input  wire logic clk,
	input  wire logic rstn,
	input  wire logic din,
	output logic      dout
);
	logic meta_q;
	logic meta_d;
	logic sync_q;
	logic sync_d;

	always_comb
	begin
		meta_d = din;
		sync_d = meta_q;
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			meta_q <= 1'b1;
			sync_q <= 1'b1;
		end
		else
		begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign dout = sync_q;
endmodule : ebmp_sync

/* ebmp_arbiter.sv */
// Arbiter and other-master model on the far side of the port
`timescale 1ns/1ps
module ebmp_arbiter (
	input  wire logic clk,
	input  wire logic rstn,
	input  wire logic allow,
	input  wire logic other_busy,
	input  wire logic drive_n,
	input  wire logic drive_oe,
	output logic      grant_in_n,
	output logic      shared_busy_n
);
	logic other_q;
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			grant_in_n <= 1'h1;
			other_q    <= 1'h0;
		end
		else
		begin
			grant_in_n <= !allow;
			other_q    <= other_busy;
		end
	end
	// Pull-up holds the line high when nobody drives it
	assign shared_busy_n = drive_oe ? drive_n : !other_q;
endmodule : ebmp_arbiter

/* ebmp_port_bench.sv */
// Self-checking bench of the bus mastership port
`timescale 1ns/1ps
module ebmp_port_bench;
	logic clk = 1'h0, rstn = 1'h0, need = 1'h0, act = 1'h0, cend = 1'h0, hold = 1'h0;
	logic mse = 1'h0, bce = 1'h0, cas = 1'h0, allow = 1'h0, oth = 1'h0, prev;
	logic grant_n, busy, bo, boe, req_n, own, cs_n, cs_oe, bc, bc_oe, bcn, bcn_oe;
	int   fail_count = 0, check_count = 0, cycles = 0, i;
	// Rows: need, hold, strobe enable, request_n, strobe oe
	logic [4:0] rows [4] = '{5'h02, 5'h15, 5'h08, 5'h07};
	ebmp_arbiter i_arb (.clk(clk), .rstn(rstn), .allow(allow), .other_busy(oth),
		.drive_n(bo), .drive_oe(boe), .grant_in_n(grant_n), .shared_busy_n(busy));
	ebmp_port i_dut (.clk(clk), .rstn(rstn), .grant_in_n(grant_n), .shared_busy_n_i(busy),
		.shared_busy_n_o(bo), .shared_busy_n_oe(boe), .request_out_n(req_n),
		.bus_need(need), .cycle_active(act), .cycle_end(cend), .request_hold_bit(hold),
		.mastership_strobe_enable(mse), .bus_clock_enable(bce), .cas_req(cas),
		.owner(own), .col_strobe_n_o(cs_n), .col_strobe_n_oe(cs_oe), .bus_clock_o(bc),
		.bus_clock_oe(bc_oe), .bus_clock_n_o(bcn), .bus_clock_n_oe(bcn_oe));
	always #20 clk = ~clk;
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : give_verdict
	task automatic chk(input logic got, input logic exp);
		check_count++;
		if (got !== exp)
		begin
			fail_count++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask : cyc
	task automatic wait_own(input logic v);
		@(negedge clk);
		for (i = 0; i < 20 && own !== v; i++) @(negedge clk);
	endtask : wait_own
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			fail_count++;
			give_verdict();
		end
	end
	initial
	begin
		repeat (20) @(posedge clk);
		rstn  <= 1'h1;
		allow <= 1'h1;
		cyc(1);
		chk(req_n, 1'h1);
		chk(bc_oe, 1'h0);
		cyc(6);
		chk(own, 1'h0);
		chk(boe, 1'h0);
		@(posedge clk);
		allow <= 1'h0;
		cyc(4);
		$display("reset done");
		foreach (rows[k])
		begin
			@(posedge clk);
			{need, hold, mse} <= rows[k][4:2];
			cyc(3);
			chk(req_n, rows[k][1]);
			chk(cs_oe, rows[k][0]);
		end
		$display("table done");
		@(posedge clk);
		{need, oth, allow, bce, mse, cas} <= 6'h3d;
		cyc(8);
		chk(own, 1'h0);
		@(posedge clk);
		oth <= 1'h0;
		wait_own(1'h1);
		chk(own, 1'h1);
		cyc(2);
		chk(busy, 1'h0);
		chk(cs_oe, 1'h1);
		chk(cs_n, 1'h0);
		chk(bcn_oe, 1'h1);
		chk(bc_oe, 1'h1);
		prev = bc;
		cyc(1);
		chk(bc, ~prev);
		chk(bcn, ~bc);
		@(posedge clk);
		bce <= 1'h0;
		cyc(2);
		prev = bc;
		cyc(1);
		chk(bc, prev);
		$display("take done");
		@(posedge clk);
		need <= 1'h0;
		cas  <= 1'h0;
		cyc(6);
		chk(own, 1'h1);
		chk(busy, 1'h0);
		chk(req_n, 1'h1);
		chk(cs_n, 1'h1);
		$display("park done");
		@(posedge clk);
		{need, act, allow} <= 3'h6;
		cyc(6);
		chk(own, 1'h1);
		@(posedge clk);
		{act, cend} <= 2'h3;
		@(posedge clk);
		{need, act, cend} <= 3'h0;
		cyc(1);
		chk(own, 1'h0);
		chk(bo, 1'h1);
		chk(boe, 1'h1);
		cyc(1);
		chk(boe, 1'h0);
		chk(busy, 1'h1);
		chk(bcn_oe, 1'h0);
		chk(cs_oe, 1'h0);
		$display("release done");
		@(posedge clk);
		{need, allow} <= 2'h3;
		wait_own(1'h1);
		chk(own, 1'h1);
		chk(busy, 1'h0);
		@(posedge clk);
		need <= 1'h0;
		cyc(3);
		chk(own, 1'h1);
		chk(req_n, 1'h1);
		@(posedge clk);
		allow <= 1'h0;
		wait_own(1'h0);
		chk(own, 1'h0);
		chk(bo, 1'h1);
		cyc(1);
		chk(boe, 1'h0);
		chk(busy, 1'h1);
		$display("parked release done");
		@(posedge clk);
		{need, allow} <= 2'h3;
		wait_own(1'h1);
		@(posedge clk);
		rstn <= 1'h0;
		cyc(1);
		chk(own, 1'h0);
		chk(req_n, 1'h1);
		chk(boe, 1'h0);
		cyc(2);
		@(posedge clk);
		rstn <= 1'h1;
		cyc(1);
		chk(req_n, 1'h1);
		chk(own, 1'h0);
		wait_own(1'h1);
		chk(own, 1'h1);
		$display("mid-run reset done");
		give_verdict();
	end
endmodule : ebmp_port_bench
